// >>> core/modbus_meter_map.vh
// Operation
// - Flow float upper half at holding 0x13, lower half at 0x14.
// - Total float upper half at holding 0x15, lower half at 0x16.
// - Temperature float upper half at holding 0x19, lower half at 0x1a.
// - Elapsed hours float upper half at holding 0x1b, lower at 0x1c.
// - Zero-check result float upper half at 0x1d, lower half at 0x1e.
// - Scaled 16-bit flow and total registers saturate at all ones on overflow.
// - Control register 0x11 is write only and reads back as zero.
// - Function 04 status read answers byte count of twice the register count, high byte first.
// - Status bit 0 is set at power up, cleared once start-up finishes.
// - Bits 1 to 4 flag flow/temperature limits; zero limit never flags.
// - Bits 5, 6, 7 flag sensor range, gas mix and bad settings.
// - Bit 8 shows simulation, which is off while simulation value is zero.
// - Bit 9 pulse output range, bit 10 analog range, bits 11-13 zero.
// - Bit 14 parameter checksum error; bit 15 total error, cleared by reset.
// - Second status: pulse hardware, busy, two zeros, then zero-check flags.
// - Function 06 to 0x0011 is answered by echoing function, address, data.
// - Writing 0x0002 to the control register clears total and elapsed time.
// - Requests carry function, start and count, each high byte first.
`ifndef MODBUS_METER_MAP_VH
`define MODBUS_METER_MAP_VH

`define FN_READ_HOLD 8'h03
`define FN_READ_INPUT 8'h04
`define FN_WRITE_ONE 8'h06
`define FN_EXC_FLAG 8'h80

`define EXC_BAD_FUNC 8'h01
`define EXC_BAD_ADDR 8'h02
`define EXC_BAD_VALUE 8'h03

`define MAX_HOLD_COUNT 16'h007d
`define INPUT_REG_COUNT 17'h00002

`define HR_FLOW_X10 16'h000a
`define HR_FLOW_X100 16'h000b
`define HR_TOTAL_X100 16'h000c
`define HR_STATUS 16'h000f
`define HR_STATUS2 16'h0010
`define HR_CONTROL 16'h0011
`define HR_FLOW_HI 16'h0013
`define HR_FLOW_LO 16'h0014
`define HR_TOTAL_HI 16'h0015
`define HR_TOTAL_LO 16'h0016
`define HR_TEMP_HI 16'h0019
`define HR_TEMP_LO 16'h001a
`define HR_ELAPSED_HI 16'h001b
`define HR_ELAPSED_LO 16'h001c
`define HR_ZCHECK_HI 16'h001d
`define HR_ZCHECK_LO 16'h001e

`define IR_STATUS 16'h0000
`define IR_STATUS2 16'h0001

`define CTRL_RESET_TOTAL 16'h0002

`define ST_POWER_UP 0
`define ST_FLOW_HIGH 1
`define ST_FLOW_LOW 2
`define ST_TEMP_HIGH 3
`define ST_TEMP_LOW 4
`define ST_SENSOR_RANGE 5
`define ST_GAS_MIX 6
`define ST_SETTINGS 7
`define ST_SIMULATION 8
`define ST_PULSE_RANGE 9
`define ST_ANALOG_RANGE 10
`define ST_PARAM_CRC 14
`define ST_TOTAL_ERR 15

`define S2_PULSE_HW 0
`define S2_BUSY 1
`define S2_ZC_RUN 4
`define S2_ZC_FAIL 5
`define S2_ZC_ABORT 6
`define S2_ZC_WARN 7

`endif

// >>> core/modbus_meter_regs.v
`timescale 1ns/100ps
`include "modbus_meter_map.vh"
module modbus_meter_regs
(
   input wire sys_clk,
   input wire arst_n,
   input wire req_valid,
   output wire req_ready,
   input wire [7:0] req_func,
   input wire [15:0] req_addr,
   input wire [15:0] req_count,
   input wire [15:0] req_data,
   output reg rsp_valid,
   input wire rsp_ready,
   output reg [7:0] rsp_byte,
   output reg rsp_last,
   output reg total_elapsed_clear,
   input wire [31:0] flow_float,
   input wire [31:0] total_float,
   input wire [31:0] temp_float,
   input wire [31:0] elapsed_float,
   input wire [31:0] zero_check_float,
   input wire [31:0] flow_x10,
   input wire [31:0] flow_x100,
   input wire [31:0] total_x100,
   input wire [31:0] flow_value,
   input wire [31:0] flow_high_limit,
   input wire [31:0] flow_low_limit,
   input wire [31:0] temp_value,
   input wire [31:0] temp_high_limit,
   input wire [31:0] temp_low_limit,
   input wire [31:0] sim_value,
   input wire powerup_done,
   input wire sensor_range_err,
   input wire gas_mix_err,
   input wire settings_err,
   input wire pulse_range_err,
   input wire analog_range_err,
   input wire param_crc_err,
   input wire total_err_event,
   input wire pulse_hw_present,
   input wire busy,
   input wire zc_running,
   input wire zc_fail,
   input wire zc_aborted,
   input wire zc_warning
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_LOAD = 3'b010;
   localparam [2:0] ST_SEND = 3'b100;

   localparam [1:0] KIND_READ = 2'h0;
   localparam [1:0] KIND_WRITE = 2'h1;
   localparam [1:0] KIND_EXC = 2'h2;

   reg [2:0] state;
   reg [1:0] kind;
   reg [7:0] func, exc_code, len, idx;
   reg [15:0] start_addr, wr_data;
   reg power_up, total_err;

   wire [95:0] scaled_in;
   wire [47:0] scaled_word;
   genvar g;

   reg [15:0] status_word, status2_word, word_addr;
   reg [15:0] hold_val, in_val, data_word;
   reg [7:0] sel_idx, word_idx, next_byte, dec_exc, dec_len;
   reg [1:0] dec_kind;
   reg [16:0] in_end;

   assign req_ready = (state == ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Scaled integer words.

   assign scaled_in = {total_x100, flow_x100, flow_x10};

   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_sat
         sat16 u_sat
         (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .value(scaled_in[32*g+31:32*g]),
            .word(scaled_word[16*g+15:16*g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Status words.

   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         power_up <= 1'b1;
      else if (powerup_done)
         power_up <= 1'b0;
   end

   // An error event in the same cycle as a total reset keeps the flag set.
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         total_err <= 1'b0;
      else if (total_err_event)
         total_err <= 1'b1;
      else if (total_elapsed_clear)
         total_err <= 1'b0;
   end

   always @*
   begin
      status_word = 16'h0000;
      status_word[`ST_POWER_UP] = power_up;
      status_word[`ST_FLOW_HIGH] = (flow_high_limit != 32'h0) &&
         (flow_value >= flow_high_limit);
      status_word[`ST_FLOW_LOW] = (flow_low_limit != 32'h0) &&
         (flow_value <= flow_low_limit);
      status_word[`ST_TEMP_HIGH] = (temp_high_limit != 32'h0) &&
         (temp_value >= temp_high_limit);
      status_word[`ST_TEMP_LOW] = (temp_low_limit != 32'h0) &&
         (temp_value <= temp_low_limit);
      status_word[`ST_SENSOR_RANGE] = sensor_range_err;
      status_word[`ST_GAS_MIX] = gas_mix_err;
      status_word[`ST_SETTINGS] = settings_err;
      status_word[`ST_SIMULATION] = (sim_value != 32'h0);
      status_word[`ST_PULSE_RANGE] = pulse_range_err;
      status_word[`ST_ANALOG_RANGE] = analog_range_err;
      status_word[`ST_PARAM_CRC] = param_crc_err;
      status_word[`ST_TOTAL_ERR] = total_err;
   end

   always @*
   begin
      status2_word = 16'h0000;
      status2_word[`S2_PULSE_HW] = pulse_hw_present;
      status2_word[`S2_BUSY] = busy;
      status2_word[`S2_ZC_RUN] = zc_running;
      status2_word[`S2_ZC_FAIL] = zc_fail;
      status2_word[`S2_ZC_ABORT] = zc_aborted;
      status2_word[`S2_ZC_WARN] = zc_warning;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read multiplexers.

   // Words are sampled as each byte is loaded, so the two halves of a float
   // can come from different updates if the source changes mid-answer.
   always @*
   begin
      sel_idx = (state == ST_LOAD) ? 8'h00 : idx + 8'h01;
      word_idx = sel_idx - 8'h02;
      word_addr = start_addr + {9'h000, word_idx[7:1]};
   end

   always @*
   begin
      if (word_addr == `HR_FLOW_X10)
         hold_val = scaled_word[15:0];
      else if (word_addr == `HR_FLOW_X100)
         hold_val = scaled_word[31:16];
      else if (word_addr == `HR_TOTAL_X100)
         hold_val = scaled_word[47:32];
      else if (word_addr == `HR_STATUS)
         hold_val = status_word;
      else if (word_addr == `HR_STATUS2)
         hold_val = status2_word;
      else if (word_addr == `HR_FLOW_HI)
         hold_val = flow_float[31:16];
      else if (word_addr == `HR_FLOW_LO)
         hold_val = flow_float[15:0];
      else if (word_addr == `HR_TOTAL_HI)
         hold_val = total_float[31:16];
      else if (word_addr == `HR_TOTAL_LO)
         hold_val = total_float[15:0];
      else if (word_addr == `HR_TEMP_HI)
         hold_val = temp_float[31:16];
      else if (word_addr == `HR_TEMP_LO)
         hold_val = temp_float[15:0];
      else if (word_addr == `HR_ELAPSED_HI)
         hold_val = elapsed_float[31:16];
      else if (word_addr == `HR_ELAPSED_LO)
         hold_val = elapsed_float[15:0];
      else if (word_addr == `HR_ZCHECK_HI)
         hold_val = zero_check_float[31:16];
      else if (word_addr == `HR_ZCHECK_LO)
         hold_val = zero_check_float[15:0];
      else
         hold_val = 16'h0000;
   end

   always @*
   begin
      if (word_addr == `IR_STATUS)
         in_val = status_word;
      else if (word_addr == `IR_STATUS2)
         in_val = status2_word;
      else
         in_val = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer byte generator.

   always @*
   begin
      data_word = (func == `FN_READ_INPUT) ? in_val : hold_val;
      next_byte = 8'h00;
      case (kind)
         KIND_READ:
         begin
            if (sel_idx == 8'h00)
               next_byte = func;
            else if (sel_idx == 8'h01)
               next_byte = len - 8'h02;
            else if (word_idx[0] == 1'b0)
               next_byte = data_word[15:8];
            else
               next_byte = data_word[7:0];
         end
         KIND_WRITE:
         begin
            if (sel_idx == 8'h00)
               next_byte = func;
            else if (sel_idx == 8'h01)
               next_byte = start_addr[15:8];
            else if (sel_idx == 8'h02)
               next_byte = start_addr[7:0];
            else if (sel_idx == 8'h03)
               next_byte = wr_data[15:8];
            else
               next_byte = wr_data[7:0];
         end
         default:
         begin
            if (sel_idx == 8'h00)
               next_byte = func | `FN_EXC_FLAG;
            else
               next_byte = exc_code;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request decode.

   always @*
   begin
      in_end = {1'b0, req_addr} + {1'b0, req_count};
      dec_kind = KIND_EXC;
      dec_exc = `EXC_BAD_FUNC;
      dec_len = 8'h02;
      if (req_func == `FN_READ_HOLD)
      begin
         if (req_count == 16'h0000 || req_count > `MAX_HOLD_COUNT)
            dec_exc = `EXC_BAD_VALUE;
         else
         begin
            dec_kind = KIND_READ;
            dec_len = {req_count[6:0], 1'b0} + 8'h02;
         end
      end
      else if (req_func == `FN_READ_INPUT)
      begin
         if (req_count == 16'h0000 ||
             {1'b0, req_count} > `INPUT_REG_COUNT)
            dec_exc = `EXC_BAD_VALUE;
         else if (in_end > `INPUT_REG_COUNT)
            dec_exc = `EXC_BAD_ADDR;
         else
         begin
            dec_kind = KIND_READ;
            dec_len = {req_count[6:0], 1'b0} + 8'h02;
         end
      end
      else if (req_func == `FN_WRITE_ONE)
      begin
         dec_kind = KIND_WRITE;
         dec_len = 8'h05;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transaction control.

   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         kind <= KIND_EXC;
         func <= 8'h00;
         start_addr <= 16'h0000;
         wr_data <= 16'h0000;
         exc_code <= 8'h00;
         len <= 8'h00;
         idx <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_last <= 1'b0;
         total_elapsed_clear <= 1'b0;
      end
      else
      begin
         total_elapsed_clear <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (req_valid)
               begin
                  kind <= dec_kind;
                  func <= req_func;
                  start_addr <= req_addr;
                  wr_data <= req_data;
                  exc_code <= dec_exc;
                  len <= dec_len;
                  // Only the control register acts on a write.
                  if (req_func == `FN_WRITE_ONE && req_addr == `HR_CONTROL &&
                      req_data == `CTRL_RESET_TOTAL)
                     total_elapsed_clear <= 1'b1;
                  state <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               idx <= 8'h00;
               rsp_byte <= next_byte;
               rsp_last <= (len == 8'h01);
               rsp_valid <= 1'b1;
               state <= ST_SEND;
            end
            ST_SEND:
            begin
               if (rsp_ready)
               begin
                  if (rsp_last)
                  begin
                     rsp_valid <= 1'b0;
                     rsp_last <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     idx <= idx + 8'h01;
                     rsp_byte <= next_byte;
                     rsp_last <= (idx + 8'h02 == len);
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule

// >>> core/sat16.v
`timescale 1ns/100ps
// Registered clamp of an unsigned 32-bit scaled value into one 16-bit word.
module sat16
(
   input wire sys_clk,
   input wire arst_n,
   input wire [31:0] value,
   output reg [15:0] word
);

   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         word <= 16'h0000;
      else if (value[31:16] != 16'h0000)
         word <= 16'hffff;
      else
         word <= value[15:0];
   end

endmodule

// >>> dv/mb_master_model.sv
`timescale 1ns/100ps
module mb_master_model
(
   input wire sys_clk,
   input wire arst_n,
   input wire slow,
   output logic req_valid = 1'b0,
   output logic [7:0] req_func = 8'h00,
   output logic [15:0] req_addr = 16'h0000,
   output logic [15:0] req_count = 16'h0000,
   output logic [15:0] req_data = 16'h0000,
   input wire req_ready,
   input wire rsp_valid,
   output logic rsp_ready,
   input wire [7:0] rsp_byte,
   input wire rsp_last
);
   logic [7:0] got [0:31];
   logic [7:0] n;
   logic done;
   // Released fields flip so a stale request is never mistaken for a new one.
   task automatic send(input logic [7:0] f, input logic [15:0] a, c, d);
      begin
         req_valid <= 1'b1;
         req_func <= f;
         req_addr <= a;
         req_count <= c;
         req_data <= d;
         @(posedge sys_clk);
         while (req_ready !== 1'b1) @(posedge sys_clk);
         req_valid <= 1'b0;
         req_func <= ~f;
         req_addr <= ~a;
         req_count <= ~c;
         req_data <= ~d;
      end
   endtask
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsp_ready <= 1'b0;
         n <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         rsp_ready <= slow ? ~rsp_ready : 1'b1;
         if (req_valid && req_ready)
         begin
            n <= 8'h00;
            done <= 1'b0;
         end
         else if (rsp_valid && rsp_ready)
         begin
            got[n[4:0]] <= rsp_byte;
            n <= n + 8'h01;
            done <= rsp_last;
         end
      end
   end
endmodule

// >>> dv/modbus_meter_regs_chk.sv
`timescale 1ns/100ps
module modbus_meter_regs_chk
(
   input wire sys_clk,
   input wire arst_n,
   input wire req_valid,
   input wire req_ready,
   input wire [7:0] req_func,
   input wire [15:0] req_addr,
   input wire [15:0] req_count,
   input wire [15:0] req_data,
   input wire rsp_valid,
   input wire rsp_ready,
   input wire [7:0] rsp_byte,
   input wire rsp_last,
   input wire total_elapsed_clear
);
   wire take = req_valid && req_ready;
   wire rst_cmd = take && req_func == 8'h06 && req_addr == 16'h0011
      && req_data == 16'h0002;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_CLR_CAUSE:
      assert property (rst_cmd |=> total_elapsed_clear)
      else $error("no clear pulse");
   AST_CLR_ONLY:
      assert property (total_elapsed_clear |-> $past(rst_cmd))
      else $error("stray clear pulse");
   AST_CLR_PULSE:
      assert property (total_elapsed_clear |=> !total_elapsed_clear)
      else $error("clear too long");
   AST_LATENCY:
      assert property (take |=> !rsp_valid ##1 rsp_valid)
      else $error("answer latency");
   AST_STATUS_FN:
      assert property (take && req_func == 8'h04 && req_addr == 16'h0000
         && req_count == 16'h0001 |-> ##2 rsp_byte == 8'h04)
      else $error("status answer func");
   AST_ECHO_FN:
      assert property (take && req_func == 8'h06 |-> ##2 rsp_byte == 8'h06)
      else $error("echo func");
   AST_HOLD:
      assert property (rsp_valid && !rsp_ready |=>
         rsp_valid && $stable(rsp_byte) && $stable(rsp_last))
      else $error("byte not held");
   AST_END:
      assert property (rsp_valid && rsp_ready && rsp_last |=>
         !rsp_valid && req_ready)
      else $error("answer end");
endmodule
bind modbus_meter_regs modbus_meter_regs_chk chk (.sys_clk(sys_clk),
   .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
   .req_func(req_func), .req_addr(req_addr), .req_count(req_count),
   .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
   .rsp_byte(rsp_byte), .rsp_last(rsp_last),
   .total_elapsed_clear(total_elapsed_clear));

// >>> dv/tb_modbus_meter_regs.sv
`timescale 1ns/100ps
`include "modbus_meter_map.vh"
module tb_modbus_meter_regs;
   logic sys_clk = 1'b0, arst_n = 1'b0, slow = 1'b0;
   logic powerup_done = 1'b0, total_err_event = 1'b0;
   logic sensor_range_err = 1'b1, gas_mix_err = 1'b0, settings_err = 1'b1;
   logic pulse_range_err = 1'b0, analog_range_err = 1'b1, param_crc_err = 1'b1;
   logic pulse_hw_present = 1'b1, busy = 1'b0, zc_running = 1'b1;
   logic zc_fail = 1'b0, zc_aborted = 1'b1, zc_warning = 1'b0;
   logic [31:0] flow_float = 32'h11223344, total_float = 32'h55667788;
   logic [31:0] temp_float = 32'h99aabbcc, elapsed_float = 32'hddeeff01;
   logic [31:0] zero_check_float = 32'h02030405, flow_x10 = 32'h00010000;
   logic [31:0] flow_x100 = 32'h0000ffff, total_x100 = 32'h00001234;
   logic [31:0] flow_value = 32'h00000064, temp_value = 32'h00000005;
   logic [31:0] flow_high_limit = 32'h0, flow_low_limit = 32'h0;
   logic [31:0] temp_high_limit = 32'h0, temp_low_limit = 32'h0;
   logic [31:0] sim_value = 32'h0;
   logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_last;
   logic total_elapsed_clear;
   logic [7:0] req_func, rsp_byte, clr_n = 8'h00;
   logic [15:0] req_addr, req_count, req_data;
   logic [7:0] exp_q [$];
   int fails = 0, tests_run = 0, cyc = 0;
   mb_master_model m (.sys_clk, .arst_n, .slow, .req_valid, .req_func,
      .req_addr, .req_count, .req_data, .req_ready, .rsp_valid, .rsp_ready,
      .rsp_byte, .rsp_last);
   modbus_meter_regs dut (.sys_clk, .arst_n, .req_valid, .req_ready,
      .req_func, .req_addr, .req_count, .req_data, .rsp_valid, .rsp_ready,
      .rsp_byte, .rsp_last, .total_elapsed_clear, .flow_float, .total_float,
      .temp_float, .elapsed_float, .zero_check_float, .flow_x10, .flow_x100,
      .total_x100, .flow_value, .flow_high_limit, .flow_low_limit,
      .temp_value, .temp_high_limit, .temp_low_limit, .sim_value,
      .powerup_done, .sensor_range_err, .gas_mix_err, .settings_err,
      .pulse_range_err, .analog_range_err, .param_crc_err, .total_err_event,
      .pulse_hw_present, .busy, .zc_running, .zc_fail, .zc_aborted,
      .zc_warning);
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      begin
         $display("compares %0d, mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task automatic bad(input string s);
      begin
         fails++;
         $display("BAD t=%0t %s", $time, s);
      end
   endtask
   task automatic chk8(input logic [7:0] g, e);
      begin
         tests_run++;
         if (g !== e)
            bad($sformatf("got %h want %h", g, e));
      end
   endtask
   task automatic wq(input logic [15:0] v [$]);
      begin
         foreach (v[i])
         begin
            exp_q.push_back(v[i][15:8]);
            exp_q.push_back(v[i][7:0]);
         end
      end
   endtask
   // Byte count is checked before contents so a short answer is reported.
   task automatic txn(input logic [7:0] f, input logic [15:0] a, c, d);
      int k;
      begin
         k = 0;
         m.send(f, a, c, d);
         do
         begin
            @(posedge sys_clk);
            k++;
         end
         while (m.done !== 1'b1 && k < 300);
         repeat (2) @(posedge sys_clk);
         chk8(m.n, 8'(exp_q.size()));
         foreach (exp_q[i])
            chk8(m.got[i], exp_q[i]);
         exp_q.delete();
         $display("test end: func %h addr %h", f, a);
      end
   endtask
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (total_elapsed_clear === 1'b1)
         clr_n <= clr_n + 8'h01;
      if (cyc == 5000)
      begin
         bad("timeout");
         wrap_up;
      end
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      exp_q = {8'h04, 8'h02};
      wq({16'h44a1});
      txn(8'h04, `IR_STATUS, 16'h0001, 16'h0);
      exp_q = {8'h04, 8'h02};
      wq({16'h0051});
      txn(8'h04, `IR_STATUS2, 16'h0001, 16'h0);
      flow_high_limit <= 32'h00000064;
      flow_low_limit <= 32'h00000032;
      temp_high_limit <= 32'h00000009;
      temp_low_limit <= 32'h00000005;
      sim_value <= 32'h00000007;
      powerup_done <= 1'b1;
      total_err_event <= 1'b1;
      @(posedge sys_clk);
      powerup_done <= 1'b0;
      total_err_event <= 1'b0;
      exp_q = {8'h04, 8'h02};
      wq({16'hc5b2});
      txn(8'h04, `IR_STATUS, 16'h0001, 16'h0);
      slow <= 1'b1;
      exp_q = {8'h06, 8'h00, 8'h11, 8'h00, 8'h02};
      txn(8'h06, `HR_CONTROL, 16'h0, 16'h0002);
      chk8(clr_n, 8'h01);
      slow <= 1'b0;
      exp_q = {8'h06, 8'h00, 8'h11, 8'h00, 8'h03};
      txn(8'h06, `HR_CONTROL, 16'h0, 16'h0003);
      exp_q = {8'h06, 8'h00, 8'h12, 8'h00, 8'h02};
      txn(8'h06, 16'h0012, 16'h0, 16'h0002);
      chk8(clr_n, 8'h01);
      exp_q = {8'h03, 8'h10};
      wq({16'hffff, 16'hffff, 16'h1234, 16'h0, 16'h0, 16'h45b2, 16'h0051,
         16'h0});
      txn(8'h03, `HR_FLOW_X10, 16'h0008, 16'h0);
      exp_q = {8'h03, 8'h18};
      wq({flow_float[31:16], flow_float[15:0], total_float[31:16],
         total_float[15:0], 16'h0, 16'h0, temp_float[31:16],
         temp_float[15:0], elapsed_float[31:16], elapsed_float[15:0],
         zero_check_float[31:16], zero_check_float[15:0]});
      txn(8'h03, `HR_FLOW_HI, 16'h000c, 16'h0);
      exp_q = {8'h85, 8'h01};
      txn(8'h05, 16'h0000, 16'h0001, 16'h0);
      exp_q = {8'h83, 8'h03};
      txn(8'h03, `HR_FLOW_HI, 16'h0000, 16'h0);
      exp_q = {8'h84, 8'h02};
      txn(8'h04, `IR_STATUS2, 16'h0002, 16'h0);
      // A second reset must bring the power-up flag back and drop the total
      // error; the levels are inverted so every status bit is seen high.
      total_err_event <= 1'b1;
      @(posedge sys_clk);
      total_err_event <= 1'b0;
      arst_n <= 1'b0;
      flow_value <= 32'h00000032;
      temp_value <= 32'h00000009;
      sensor_range_err <= 1'b0;
      gas_mix_err <= 1'b1;
      settings_err <= 1'b0;
      pulse_range_err <= 1'b1;
      analog_range_err <= 1'b0;
      param_crc_err <= 1'b0;
      pulse_hw_present <= 1'b0;
      busy <= 1'b1;
      zc_running <= 1'b0;
      zc_fail <= 1'b1;
      zc_aborted <= 1'b0;
      zc_warning <= 1'b1;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      exp_q = {8'h04, 8'h04};
      wq({16'h034d, 16'h00a2});
      txn(8'h04, `IR_STATUS, 16'h0002, 16'h0);
      wrap_up;
   end
endmodule
